/* dv/test_video_dac_input_coder.sv */
/*
 * Self-checking bench for the video converter input coder.
 * Assumes the coder answers two edges after a pixel is taken.
 */
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
	$display("BAD %s expected %h seen %h", n, e, s); end end

module test_video_dac_input_coder;
	timeunit 1ns;
	timeprecision 1ps;
	import vdc_pkg::*;

	logic clk;
	logic rst_b;
	logic pix_valid;
	logic pix_ready;
	vdc_pixel_t pix_in;
	vdc_switch_t sw_out;
	logic sw_valid;
	logic [15:0] level_mv;
	int bad_count;
	int comparisons;
	vdc_switch_t exp_q[$];
	logic [15:0] lev_q[$];

	vdc_coder #(.FIFO_DEPTH(4)) uut (.clk(clk), .rst_b(rst_b), .pix_valid(pix_valid),
		.pix_ready(pix_ready), .pix_in(pix_in), .sw_out(sw_out), .sw_valid(sw_valid),
		.level_mv(level_mv));
	vdc_src_model src (.clk(clk), .pix_ready(pix_ready), .pix_valid(pix_valid),
		.pix_in(pix_in));

	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Expected switch pattern: a set bit is a switch that is on.
	function automatic vdc_switch_t exp_sw(input vdc_pixel_t p);
		vdc_switch_t s;
		logic [9:0] e;
		logic [5:0] m;
		s = '1;
		e = p.inverse ? ~p.data : p.data;
		m = ~e[9:4];
		if (!p.sync && p.blank)
			s.sync_sw = 1'b0;
		if (!p.sync && !p.blank) begin
			for (int i = 0; i < VDC_SEG_N; i++)
				s.seg[i] = (int'(m) > i);
			s.lsb = ~e[3:0];
			s.blank_sw = 1'b0;
			s.sync_sw = 1'b0;
		end
		return s;
	endfunction

	function automatic logic [15:0] exp_lev(input vdc_pixel_t p);
		logic [9:0] e;
		e = p.inverse ? ~p.data : p.data;
		if (p.sync)
			return 16'(VDC_SYNC_MV);
		if (p.blank)
			return 16'(VDC_BLANK_MV);
		return 16'(VDC_BLACK_MV + int'(e) * (VDC_WHITE_MV - VDC_BLACK_MV) / 1023);
	endfunction

	task automatic push(input vdc_pixel_t p);
		exp_q.push_back(exp_sw(p));
		lev_q.push_back(exp_lev(p));
		src.send(p);
	endtask

	// Lets the pipeline empty, then every expected word must have appeared.
	task automatic drain();
		repeat (4) @(posedge clk);
		`CHK("pending", 0, exp_q.size())
	endtask

	// Each latched pattern is matched against the queue in order of sending.
	always @(posedge clk) begin
		vdc_switch_t es;
		logic [15:0] el;
		if (rst_b === 1'b1 && sw_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHK("extra", 1'b0, sw_valid)
			end else begin
				es = exp_q.pop_front();
				el = lev_q.pop_front();
				`CHK("sw_out", es, sw_out)
				`CHK("level_mv", el, level_mv)
			end
		end
	end

	task automatic t_reset();
		`CHK("rst sw_valid", 1'b0, sw_valid)
		`CHK("rst sw_out", vdc_switch_t'(0), sw_out)
		`CHK("rst level", VDC_MV_RESET, level_mv)
		`CHK("rst ready", 1'b0, pix_ready)
	endtask

	// Reset in mid-run with the pipeline idle: outputs clear, the port reopens, work resumes.
	task automatic t_rst_mid();
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("mid sw_valid", 1'b0, sw_valid)
		`CHK("mid sw_out", vdc_switch_t'(0), sw_out)
		`CHK("mid level", VDC_MV_RESET, level_mv)
		`CHK("mid ready", 1'b0, pix_ready)
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK("ready", 1'b1, pix_ready)
		push({3'b000, 10'h3ff});
		drain();
	endtask

	// Full scale, zero, and thermometer boundaries, with and without inverse.
	task automatic t_gray();
		logic [9:0] tbl[6];
		tbl = '{10'h3ff, 10'h000, 10'h2a5, 10'h010, 10'h3ef, 10'h00f};
		for (int inv = 0; inv < 2; inv++)
			for (int i = 0; i < 6; i++)
				push({1'b0, 1'b0, 1'(inv), tbl[i]});
		drain();
	endtask

	// Every control combination except 000; controls change every second pixel.
	task automatic t_modes();
		for (int c = 1; c < 8; c++) begin
			push({3'(c), 10'h155});
			push({3'(c), 10'h2aa});
		end
		drain();
	endtask

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run of under a hundred cycles.
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		close_out();
	end

	// Reset for 12 cycles, then the scenarios in turn.
	initial begin
		bad_count = 0;
		comparisons = 0;
		rst_b = 1'b0;
		repeat (12) @(posedge clk);
		t_reset();
		rst_b <= 1'b1;
		t_gray();
		t_modes();
		t_rst_mid();
		close_out();
	end
endmodule

/* dv/vdc_src_model.sv */
/*
 * Pixel source model: offers one pixel at a time on the valid/ready port.
 * Assumes the caller passes words with the MSB already on data bit 9.
 */
module vdc_src_model
	import vdc_pkg::*;
(
	input wire logic clk,
	input wire logic pix_ready,
	output logic pix_valid,
	output vdc_pixel_t pix_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// The port starts idle so nothing is offered during reset.
	initial begin
		pix_valid = 1'b0;
		pix_in = '0;
	end

	// Holds the word until ready is sampled high or 50 cycles pass, then releases it.
	// Released lines carry the inverse word, so stale data never matches.
	task automatic send(input vdc_pixel_t p);
		int n;
		n = 0;
		@(posedge clk);
		pix_valid <= 1'b1;
		pix_in <= p;
		do begin
			@(posedge clk);
			n++;
		end while (pix_ready !== 1'b1 && n < 50);
		pix_valid <= 1'b0;
		pix_in <= ~p;
	endtask
endmodule

/* rtl/vdc_coder.sv */
/*
 * Input coder of a 10-bit video converter: buffers pixels, decodes the upper
 * six bits into a 63-line thermometer, applies sync, blank and inverse, and
 * latches the whole switch pattern in one register stage.
 * Assumes the pixel source drives synchronous inputs and that the falling
 * conversion edge is modelled by clk rising; data bit 9 of the port is the
 * source's input bit 0 (MSB).
 */
module vdc_coder
	import vdc_pkg::*;
#(
	parameter int FIFO_DEPTH = VDC_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pix_valid,
	output logic pix_ready,
	input wire vdc_pixel_t pix_in,
	output vdc_switch_t sw_out,
	output logic sw_valid,
	output logic [15:0] level_mv
);
	localparam int PW = $bits(vdc_pixel_t);

	// Elaboration check: the buffer must hold at least two words.
	if (FIFO_DEPTH < 2) begin : g_depth_bad
		$error("vdc_coder needs a FIFO depth of at least two.");
	end

	typedef struct packed {
		vdc_switch_t sw;
		logic valid;
		logic [15:0] mv;
		logic rdy;
	} vdc_state_t;

	vdc_state_t st_q, st_d;
	logic f_in_ready, f_valid;
	logic [PW-1:0] f_data;
	vdc_pixel_t px;

	// Buffer the pixel stream; the converter drains one word per cycle.
	// Its ready output is still watched, so a stalled drain would be caught.
	vdc_fifo #(
		.WIDTH(PW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(pix_valid),
		.in_ready(f_in_ready),
		.in_data(pix_in),
		.out_valid(f_valid),
		.out_ready(1'b1),
		.out_data(f_data)
	);

	assign px = vdc_pixel_t'(f_data);

	// Thermometer decode: line i is on when the code exceeds i.
	// Lines fill from line 0 upward, so a code change moves only one boundary.
	function automatic logic [VDC_SEG_N-1:0] thermo(input logic [VDC_MSB_W-1:0] code);
		logic [VDC_SEG_N-1:0] t;
		t = '0;
		for (int i = 0; i < VDC_SEG_N; i++)
			t[i] = (7'(code) > 7'(i));
		return t;
	endfunction

	// Estimated nominal level, linear from black at code zero to white at full code.
	// It is a guide for checks only; the analog stage and its tolerances are not modelled.
	function automatic logic [15:0] gray_mv(input logic [VDC_DATA_W-1:0] code);
		int unsigned v;
		v = VDC_BLACK_MV + (int'(code) * (VDC_WHITE_MV - VDC_BLACK_MV)) / ((1 << VDC_DATA_W) - 1);
		return 16'(v);
	endfunction

	// Next switch pattern from the buffered pixel.
	always_comb begin
		logic [VDC_DATA_W-1:0] eff;
		logic [VDC_DATA_W-1:0] on_bits;
		eff = '0;
		on_bits = '0;
		st_d = st_q;
		st_d.rdy = 1'b1;
		st_d.valid = f_valid;
		if (f_valid) begin
			// Bits given as brightness; inverse flips the code only.
			eff = px.inverse ? ~px.data : px.data;
			// A switch on lowers the output, so switches are the inverted code.
			on_bits = ~eff;
			st_d.sw.seg = thermo(on_bits[VDC_DATA_W-1 -: VDC_MSB_W]);
			st_d.sw.lsb = on_bits[VDC_LSB_W-1:0];
			st_d.sw.blank_sw = 1'b0;
			st_d.sw.sync_sw = 1'b0;
			st_d.mv = gray_mv(eff);
			if (px.sync) begin
				// Sync ignores data, blank and inverse alike.
				st_d.sw.seg = '1;
				st_d.sw.lsb = '1;
				// Blank stays on under sync: the sync level sits below blank.
				st_d.sw.blank_sw = 1'b1;
				st_d.sw.sync_sw = 1'b1;
				st_d.mv = 16'(VDC_SYNC_MV);
			end else if (px.blank) begin
				st_d.sw.seg = '1;
				st_d.sw.lsb = '1;
				st_d.sw.blank_sw = 1'b1;
				st_d.mv = 16'(VDC_BLANK_MV);
			end
		end
	end

	// One register stage for all 67 lines plus controls.
	// Data and controls share this stage, so a control never lands a pixel early or late.
	// The cost is one cycle of latency on top of the buffer, which a pixel stream tolerates.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_q <= '0;
			st_q.mv <= VDC_MV_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Every output is a register bit. The buffer is popped on each cycle it holds a word,
	// so it never fills and ready comes from the state alone; a_ready_room keeps watch.
	assign sw_out = st_q.sw;
	assign sw_valid = st_q.valid;
	assign level_mv = st_q.mv;
	assign pix_ready = st_q.rdy;

	// Checks of the coding rules; one clock domain, all off while reset is low.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_sync_over_all: assert property (f_valid && px.sync |=>
		sw_out.sync_sw && sw_out.blank_sw && (&sw_out.seg) && level_mv == 16'(VDC_SYNC_MV))
		else $error("Sync pixel did not give the sync pattern.");
	a_blank_sets_segs: assert property (f_valid && px.blank && !px.sync |=>
		!sw_out.sync_sw && sw_out.blank_sw && (&sw_out.seg) && (&sw_out.lsb))
		else $error("Blank pixel did not set all segments.");
	a_normal_white: assert property (f_valid && !px.sync && !px.blank && !px.inverse
		&& (&px.data) |=> sw_out.seg == '0 && sw_out.lsb == '0 && level_mv == 16'(VDC_WHITE_MV))
		else $error("All-ones code did not give white.");
	a_inverse_white: assert property (f_valid && !px.sync && !px.blank && px.inverse
		&& px.data == '0 |=> sw_out.seg == '0 && level_mv == 16'(VDC_WHITE_MV))
		else $error("Inverted zero code did not give white.");
	a_low_bit_on: assert property (f_valid && !px.sync && !px.blank && !px.inverse
		|=> sw_out.lsb == ~$past(px.data[VDC_LSB_W-1:0]))
		else $error("Low data bit did not turn its switch on.");
	a_inv_no_level: assert property (f_valid && px.blank && !px.sync
		|=> level_mv == 16'(VDC_BLANK_MV))
		else $error("Blank level moved with inverse.");
	a_data_no_ctrl: assert property (f_valid && !px.sync && !px.blank
		|=> !sw_out.blank_sw && !sw_out.sync_sw)
		else $error("Control switch on without a control input.");

	// Popcount target for the thermometer: the on-switch value of the upper six bits.
	function automatic logic [VDC_MSB_W-1:0] on_msb(input vdc_pixel_t p);
		return p.inverse ? p.data[VDC_DATA_W-1 -: VDC_MSB_W] :
			~p.data[VDC_DATA_W-1 -: VDC_MSB_W];
	endfunction

	a_thermo_count: assert property (f_valid && !px.sync && !px.blank
		|=> $countones(sw_out.seg) == int'(on_msb($past(px))))
		else $error("Thermometer count does not match the code.");
	a_thermo_shape: assert property (sw_valid |->
		(sw_out.seg & (sw_out.seg + 1'b1)) == '0)
		else $error("Segment lines are not a thermometer.");
	a_same_edge: assert property (f_valid |=> sw_valid)
		else $error("Pattern not latched on the edge after its pixel.");

	// Level and bit-sense checks for the corners of the coding table.
	a_normal_black: assert property (f_valid && !px.sync && !px.blank && !px.inverse
		&& px.data == '0 |=> (&sw_out.seg) && (&sw_out.lsb) && level_mv == 16'(VDC_BLACK_MV))
		else $error("All-zeros code did not give black.");
	a_inverse_black: assert property (f_valid && !px.sync && !px.blank && px.inverse
		&& (&px.data) |=> (&sw_out.seg) && level_mv == 16'(VDC_BLACK_MV))
		else $error("Inverted all-ones code did not give black.");
	a_inv_low_bit: assert property (f_valid && !px.sync && !px.blank && px.inverse
		|=> sw_out.lsb == $past(px.data[VDC_LSB_W-1:0]))
		else $error("Inverse did not reverse the low bit sense.");
	a_sync_inv_level: assert property (f_valid && px.sync && px.inverse
		|=> level_mv == 16'(VDC_SYNC_MV) && (&sw_out.lsb) && sw_out.sync_sw)
		else $error("Sync level moved with inverse.");
	a_sync_with_blank: assert property (f_valid && px.sync && px.blank
		|=> level_mv == 16'(VDC_SYNC_MV) && sw_out.sync_sw)
		else $error("Blank overrode sync.");
	a_gray_range: assert property (sw_valid && !sw_out.sync_sw && !sw_out.blank_sw
		|-> level_mv >= 16'(VDC_BLACK_MV) && level_mv <= 16'(VDC_WHITE_MV))
		else $error("Gray level left the black-to-white span.");
	a_hold_idle: assert property (!f_valid |=> $stable(sw_out) && $stable(level_mv)
		&& !sw_valid)
		else $error("Pattern changed with no pixel latched.");

	// The input port: ready from the state register must never hide a full buffer.
	a_ready_room: assert property (pix_ready |-> f_in_ready)
		else $error("Ready shown while the buffer was full.");
	a_ready_after_rst: assert property ($past(rst_b) |-> pix_ready)
		else $error("Ready not high after reset ended.");

	// Main scenarios that the bench is expected to reach.
	c_sync: cover property (f_valid && px.sync);
	c_blank: cover property (f_valid && px.blank && !px.sync);
	c_inverse: cover property (f_valid && px.inverse && !px.blank && !px.sync);
	c_sync_inverse: cover property (f_valid && px.sync && px.inverse);
	c_ready_reopen: cover property ($rose(pix_ready));
endmodule

/* rtl/vdc_fifo.sv */
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
module vdc_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Elaboration check: pointers wrap by overflow, so the depth must be a power of two.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_shape_bad
		$error("vdc_fifo needs a power-of-two depth of at least two.");
	end

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} vdc_fifo_state_t;

	vdc_fifo_state_t st_q, st_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st_q.cnt != '0);
	assign out_data = mem[st_q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and count update; simultaneous push and pop keep the count.
	always_comb begin
		st_d = st_q;
		if (push)
			st_d.wp = st_q.wp + 1'b1;
		if (pop)
			st_d.rp = st_q.rp + 1'b1;
		if (push && !pop)
			st_d.cnt = st_q.cnt + 1'b1;
		else if (pop && !push)
			st_d.cnt = st_q.cnt - 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// Storage has no reset; only written words are ever read.
	always_ff @(posedge clk) begin
		if (push)
			mem[st_q.wp] <= in_data;
	end
endmodule

/* rtl/vdc_pkg.sv */
/*
 * Package for the video converter input coder: widths, control struct,
 * segment pattern struct and the nominal output levels in millivolts.
 * Assumes a single clock domain and a synchronous active-low reset.
 */
package vdc_pkg;
	localparam int VDC_DATA_W = 10;
	localparam int VDC_MSB_W = 6;
	localparam int VDC_LSB_W = 4;
	localparam int VDC_SEG_N = 63;
	localparam int VDC_STAGE_N = 67;
	localparam int VDC_FIFO_DEPTH = 4;
	// Nominal output levels, used by the level estimate in the coder.
	localparam int VDC_WHITE_MV = 5000;
	localparam int VDC_BLACK_MV = 4000;
	localparam int VDC_BLANK_MV = 3919;
	localparam int VDC_SYNC_MV = 3486;
	localparam logic [15:0] VDC_MV_RESET = 16'h0fa0;

	typedef struct packed {
		logic sync;
		logic blank;
		logic inverse;
		logic [VDC_DATA_W-1:0] data;
	} vdc_pixel_t;

	typedef struct packed {
		logic [VDC_SEG_N-1:0] seg;
		logic [VDC_LSB_W-1:0] lsb;
		logic blank_sw;
		logic sync_sw;
	} vdc_switch_t;
endpackage
